// ==== src/aiocp_fifo.sv ====
`timescale 1ns/1ps
module aiocp_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 8
) (
    input  wire logic             i_clock,
    input  wire logic             i_resetn,
    input  wire logic             i_in_valid,
    output logic                  o_in_ready,
    input  wire logic [WIDTH-1:0] i_in_data,
    output logic                  o_out_valid,
    input  wire logic             i_out_ready,
    output logic [WIDTH-1:0]      o_out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem_r [DEPTH];
    logic [AW-1:0]    wptr_r, wptr_nxt, rptr_r, rptr_nxt;
    logic [AW:0]      cnt_r, cnt_nxt;
    logic             oval_r, oval_nxt;
    logic [WIDTH-1:0] odat_r, odat_nxt;
    logic             push, pop;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb begin
        push     = i_in_valid && (cnt_r != (AW+1)'(DEPTH));
        pop      = (cnt_r != '0) && (!oval_r || i_out_ready);
        wptr_nxt = push ? wptr_r + 1'b1 : wptr_r;
        rptr_nxt = pop ? rptr_r + 1'b1 : rptr_r;
        cnt_nxt  = cnt_r + (AW+1)'(push) - (AW+1)'(pop);
        oval_nxt = pop ? 1'b1 : (i_out_ready ? 1'b0 : oval_r);
        odat_nxt = pop ? mem_r[rptr_r] : odat_r;
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            wptr_r <= '0;
            rptr_r <= '0;
            cnt_r  <= '0;
            oval_r <= 1'b0;
            odat_r <= '0;
        end else begin
            wptr_r <= wptr_nxt;
            rptr_r <= rptr_nxt;
            cnt_r  <= cnt_nxt;
            oval_r <= oval_nxt;
            odat_r <= odat_nxt;
        end
        if (push) begin
            mem_r[wptr_r] <= i_in_data;
        end
    end

    assign o_in_ready  = (cnt_r != (AW+1)'(DEPTH));
    assign o_out_valid = oval_r;
    assign o_out_data  = odat_r;

endmodule : aiocp_fifo

// ==== src/aiocp_pkg.sv ====
package aiocp_pkg;

    localparam int unsigned CLK_HZ      = 20_000_000;
    localparam int unsigned HZ_PER_MHZ  = 1_000_000;
    localparam int unsigned CYC_PER_US  = CLK_HZ / HZ_PER_MHZ;
    localparam int unsigned N_AI        = 16;
    localparam int unsigned N_AO        = 4;
    localparam int unsigned N_DIO       = 4;
    localparam int unsigned AI_W        = 24;
    localparam int unsigned AI_INT_W    = 5;
    localparam int unsigned AO_W        = 20;
    localparam int unsigned AO_INT_W    = 5;
    localparam int unsigned CODE_W      = 16;
    localparam int unsigned IVL_W       = 16;
    localparam int unsigned FIFO_DEPTH  = 8;
    localparam logic [3:0]  DIFFERENTIAL_INPUT_MODE_LIMIT_CHAN = 4'h8;
    localparam logic [IVL_W-1:0] MIN_IVL_RST_US = 16'h0008;

    // Raw code to fixed point: (pV * CAL_MULT) >> CAL_SHIFT, 19 frac bits
    localparam logic signed [20:0] CAL_MULT   = 21'sd576461;
    localparam int unsigned        CAL_SHIFT  = 40;
    localparam logic signed [10:0] NV_TO_PV   = 11'sd1000;
    // Volts (15 frac bits) to code at 320 uV per code
    localparam logic signed [13:0] AO_SCALE   = 14'sd6250;
    localparam int unsigned        AO_SHIFT   = 16;
    // nV to volts with 15 frac bits
    localparam logic signed [16:0] AO_OFF_MULT  = 17'sd35184;
    localparam int unsigned        AO_OFF_SHIFT = 30;
    localparam logic signed [31:0] AO_TYP_GAIN_NV = 32'sd320000;

    typedef enum logic [1:0] {
        AIOCP_RANGE_10V,
        AIOCP_RANGE_5V,
        AIOCP_RANGE_2V,
        AIOCP_RANGE_1V
    } aiocp_range_t;

    localparam logic signed [31:0] TYP_GAIN_PV [4] = '{
        32'sd320000000, 32'sd160000000, 32'sd64000000, 32'sd32000000
    };

    typedef struct packed {
        logic signed [31:0] gain_pv;
        logic signed [31:0] offset_nv;
    } aiocp_cal_t;

    typedef struct packed {
        logic [AI_W-1:0] data;
        logic [3:0]      chan;
        logic            last;
    } aiocp_word_t;

    localparam int unsigned WORD_W = $bits(aiocp_word_t);

endpackage : aiocp_pkg

// ==== src/aiocp_top.sv ====
`timescale 1ns/1ps
module aiocp_top (
    input  wire logic                          i_clock,
    input  wire logic                          i_resetn,
    // Configuration
    input  wire logic                          i_ai_cal_raw,
    input  wire logic                          i_ao_cal_raw,
    input  wire logic                          i_cal_stored,
    input  wire aiocp_pkg::aiocp_cal_t         i_ai_cal [4],
    input  wire aiocp_pkg::aiocp_cal_t         i_ao_cal,
    input  wire logic                          i_ivl_we,
    input  wire logic [aiocp_pkg::IVL_W-1:0]   i_ivl_us,
    input  wire logic                          i_chcfg_we,
    input  wire logic [3:0]                    i_chcfg_chan,
    input  wire aiocp_pkg::aiocp_range_t       i_chcfg_range,
    input  wire logic                          i_chcfg_differential_input_mode,
    output logic                               o_chcfg_err,
    output logic [aiocp_pkg::N_AI-1:0]         o_ai_differential_input_mode_mode,
    output logic [aiocp_pkg::IVL_W-1:0]        o_ivl_us,
    // Digital line direction
    input  wire logic [aiocp_pkg::N_DIO-1:0]   i_dio_default_out,
    input  wire logic                          i_dio_dir_we,
    input  wire logic [aiocp_pkg::N_DIO-1:0]   i_dio_dir_out,
    output logic [aiocp_pkg::N_DIO-1:0]        o_dio_oe_n,
    // Analog read request
    input  wire logic                          i_rd_req,
    input  wire logic [aiocp_pkg::N_AI-1:0]    i_rd_mask,
    output logic                               o_rd_done,
    output logic                               o_ai_valid,
    input  wire logic                          i_ai_ready,
    output aiocp_pkg::aiocp_word_t             o_ai_word,
    // Input converter
    output logic                               o_conv_start,
    output logic [3:0]                         o_conv_chan,
    output aiocp_pkg::aiocp_range_t            o_conv_range,
    output logic                               o_conv_differential_input_mode,
    input  wire logic                          i_conv_done,
    input  wire logic [aiocp_pkg::CODE_W-1:0]  i_conv_code,
    // Analog output write
    input  wire logic                          i_ao_wr,
    input  wire logic [1:0]                    i_ao_chan,
    input  wire logic [aiocp_pkg::AO_W-1:0]    i_ao_data,
    output logic                               o_ao_start,
    output logic [1:0]                         o_ao_chan,
    output logic [aiocp_pkg::CODE_W-1:0]       o_ao_code
);
    import aiocp_pkg::*;

    typedef enum {ST_IDLE, ST_WAIT, ST_CONV, ST_DONE} aiocp_state_t;

    function automatic logic [3:0] first_chan(input logic [N_AI-1:0] m);
        first_chan = '0;
        for (int i = N_AI - 1; i >= 0; i--) begin
            if (m[i]) begin
                first_chan = 4'(i);
            end
        end
    endfunction : first_chan

    function automatic logic [CODE_W-1:0] clamp16(input logic signed [47:0] v);
        if (v > 48'sd32767) begin
            clamp16 = 16'h7fff;
        end else if (v < -48'sd32768) begin
            clamp16 = 16'h8000;
        end else begin
            clamp16 = v[CODE_W-1:0];
        end
    endfunction : clamp16

    // ------------------------------------------------------------
    // Channel configuration
    // ------------------------------------------------------------
    aiocp_range_t          range_r [N_AI];
    aiocp_range_t          range_nxt [N_AI];
    logic [N_AI-1:0]       differential_input_mode_r, differential_input_mode_nxt;
    logic                  cfg_err_r, cfg_err_nxt;
    logic [IVL_W-1:0]      ivl_r, ivl_nxt;
    logic [N_DIO-1:0]      oe_n_r, oe_n_nxt;

    always_comb begin
        range_nxt   = range_r;
        differential_input_mode_nxt    = differential_input_mode_r;
        cfg_err_nxt = 1'b0;
        ivl_nxt     = i_ivl_we ? i_ivl_us : ivl_r;
        oe_n_nxt    = i_dio_dir_we ? ~i_dio_dir_out : oe_n_r;
        if (i_chcfg_we) begin
            range_nxt[i_chcfg_chan] = i_chcfg_range;
            if (i_chcfg_differential_input_mode && i_chcfg_chan >= DIFFERENTIAL_INPUT_MODE_LIMIT_CHAN) begin
                cfg_err_nxt = 1'b1;
            end else begin
                differential_input_mode_nxt[i_chcfg_chan] = i_chcfg_differential_input_mode;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            for (int i = 0; i < N_AI; i++) begin
                range_r[i] <= AIOCP_RANGE_10V;
            end
            differential_input_mode_r    <= '0;
            cfg_err_r <= 1'b0;
            ivl_r     <= MIN_IVL_RST_US;
            oe_n_r    <= ~i_dio_default_out;
        end else begin
            range_r   <= range_nxt;
            differential_input_mode_r    <= differential_input_mode_nxt;
            cfg_err_r <= cfg_err_nxt;
            ivl_r     <= ivl_nxt;
            oe_n_r    <= oe_n_nxt;
        end
    end

    // ------------------------------------------------------------
    // Input calibration
    // ------------------------------------------------------------
    logic signed [31:0] gain_pv, off_nv;
    logic signed [47:0] prod_pv;
    logic signed [68:0] fx_full;
    logic [AI_W-1:0]    ai_value;
    aiocp_range_t       conv_range_r, conv_range_nxt;

    always_comb begin
        gain_pv = i_cal_stored ? i_ai_cal[conv_range_r].gain_pv
                               : TYP_GAIN_PV[conv_range_r];
        off_nv  = i_cal_stored ? i_ai_cal[conv_range_r].offset_nv
                               : 32'sd0;
        prod_pv = 48'($signed(i_conv_code) * gain_pv)
                - 48'(off_nv * NV_TO_PV);
        fx_full = 69'(prod_pv * CAL_MULT) >>> CAL_SHIFT;
        if (i_ai_cal_raw) begin
            ai_value = AI_W'($signed(i_conv_code));
        end else begin
            ai_value = fx_full[AI_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // Sequencer and pacing
    // ------------------------------------------------------------
    aiocp_state_t     state_r, state_nxt;
    logic [N_AI-1:0]  mask_r, mask_nxt;
    logic [4:0]       div_r, div_nxt;
    logic [IVL_W-1:0] us_r, us_nxt;
    logic             start_r, start_nxt;
    logic [3:0]       conv_chan_r, conv_chan_nxt;
    logic             conv_differential_input_mode_r, conv_differential_input_mode_nxt;
    logic             done_r, done_nxt;
    logic             pace_ok, fifo_in_ready, push;
    aiocp_word_t      push_word;

    always_comb begin
        state_nxt      = state_r;
        mask_nxt       = mask_r;
        start_nxt      = 1'b0;
        done_nxt       = 1'b0;
        conv_chan_nxt  = conv_chan_r;
        conv_range_nxt = conv_range_r;
        conv_differential_input_mode_nxt  = conv_differential_input_mode_r;
        push           = 1'b0;
        push_word      = '{data: ai_value, chan: conv_chan_r,
                           last: (mask_r == '0)};
        pace_ok        = (us_r >= ivl_r);
        if (div_r == 5'(CYC_PER_US - 1)) begin
            div_nxt = '0;
            us_nxt  = (us_r == '1) ? us_r : us_r + 1'b1;
        end else begin
            div_nxt = div_r + 1'b1;
            us_nxt  = us_r;
        end
        unique case (state_r)
            ST_IDLE: begin
                if (i_rd_req) begin
                    mask_nxt  = i_rd_mask;
                    state_nxt = (i_rd_mask == '0) ? ST_DONE : ST_WAIT;
                    done_nxt  = (i_rd_mask == '0);
                end
            end
            ST_WAIT: begin
                if (pace_ok && fifo_in_ready) begin
                    start_nxt      = 1'b1;
                    conv_chan_nxt  = first_chan(mask_r);
                    conv_range_nxt = range_r[first_chan(mask_r)];
                    conv_differential_input_mode_nxt  = differential_input_mode_r[first_chan(mask_r)];
                    mask_nxt[first_chan(mask_r)] = 1'b0;
                    div_nxt        = 5'h1;
                    us_nxt         = '0;
                    state_nxt      = ST_CONV;
                end
            end
            ST_CONV: begin
                if (i_conv_done) begin
                    push = 1'b1;
                    if (mask_r == '0) begin
                        state_nxt = ST_DONE;
                        done_nxt  = 1'b1;
                    end else begin
                        state_nxt = ST_WAIT;
                    end
                end
            end
            ST_DONE: begin
                if (!i_rd_req) begin
                    state_nxt = ST_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            state_r      <= ST_IDLE;
            mask_r       <= '0;
            div_r        <= '0;
            us_r         <= '1;
            start_r      <= 1'b0;
            conv_chan_r  <= '0;
            conv_range_r <= AIOCP_RANGE_10V;
            conv_differential_input_mode_r  <= 1'b0;
            done_r       <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            mask_r       <= mask_nxt;
            div_r        <= div_nxt;
            us_r         <= us_nxt;
            start_r      <= start_nxt;
            conv_chan_r  <= conv_chan_nxt;
            conv_range_r <= conv_range_nxt;
            conv_differential_input_mode_r  <= conv_differential_input_mode_nxt;
            done_r       <= done_nxt;
        end
    end

    aiocp_fifo #(
        .WIDTH (WORD_W),
        .DEPTH (FIFO_DEPTH)
    ) u_aiocp_fifo (
        .i_clock     (i_clock),
        .i_resetn    (i_resetn),
        .i_in_valid  (push),
        .o_in_ready  (fifo_in_ready),
        .i_in_data   (push_word),
        .o_out_valid (o_ai_valid),
        .i_out_ready (i_ai_ready),
        .o_out_data  (o_ai_word)
    );

    // ------------------------------------------------------------
    // Output writes
    // ------------------------------------------------------------
    logic                ao_start_r, ao_start_nxt;
    logic [1:0]          ao_chan_r, ao_chan_nxt;
    logic [CODE_W-1:0]   ao_code_r, ao_code_nxt;
    logic signed [47:0]  ao_off_fx, ao_scaled;

    always_comb begin
        ao_off_fx    = 48'(i_ao_cal.offset_nv * AO_OFF_MULT) >>> AO_OFF_SHIFT;
        ao_scaled    = 48'(($signed(48'($signed(i_ao_data))) - ao_off_fx)
                     * AO_SCALE) >>> AO_SHIFT;
        ao_start_nxt = i_ao_wr;
        ao_chan_nxt  = i_ao_wr ? i_ao_chan : ao_chan_r;
        ao_code_nxt  = ao_code_r;
        if (i_ao_wr) begin
            if (i_ao_cal_raw) begin
                ao_code_nxt = i_ao_data[CODE_W-1:0];
            end else begin
                ao_code_nxt = clamp16(ao_scaled);
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            ao_start_r <= 1'b0;
            ao_chan_r  <= '0;
            ao_code_r  <= '0;
        end else begin
            ao_start_r <= ao_start_nxt;
            ao_chan_r  <= ao_chan_nxt;
            ao_code_r  <= ao_code_nxt;
        end
    end

    assign o_chcfg_err    = cfg_err_r;
    assign o_ai_differential_input_mode_mode = differential_input_mode_r;
    assign o_ivl_us       = ivl_r;
    assign o_dio_oe_n     = oe_n_r;
    assign o_rd_done      = done_r;
    assign o_conv_start   = start_r;
    assign o_conv_chan    = conv_chan_r;
    assign o_conv_range   = conv_range_r;
    assign o_conv_differential_input_mode    = conv_differential_input_mode_r;
    assign o_ao_start     = ao_start_r;
    assign o_ao_chan      = ao_chan_r;
    assign o_ao_code      = ao_code_r;

endmodule : aiocp_top

// ==== tb/aiocp_chk.sv ====
`timescale 1ns/1ps
module aiocp_chk (
    input wire logic                        i_clock,
    input wire logic                        i_resetn,
    input wire logic                        i_ivl_we,
    input wire logic [aiocp_pkg::IVL_W-1:0] i_ivl_us,
    input wire logic [aiocp_pkg::IVL_W-1:0] o_ivl_us,
    input wire logic                        i_chcfg_we,
    input wire logic [3:0]                  i_chcfg_chan,
    input wire logic                        i_chcfg_differential_input_mode,
    input wire logic                        o_chcfg_err,
    input wire logic [aiocp_pkg::N_AI-1:0]  o_ai_differential_input_mode_mode,
    input wire logic                        i_dio_dir_we,
    input wire logic [aiocp_pkg::N_DIO-1:0] i_dio_dir_out,
    input wire logic [aiocp_pkg::N_DIO-1:0] o_dio_oe_n,
    input wire logic                        o_rd_done,
    input wire logic                        o_conv_start,
    input wire logic                        i_ao_wr,
    input wire logic [1:0]                  i_ao_chan,
    input wire logic                        o_ao_start,
    input wire logic [1:0]                  o_ao_chan
);
    import aiocp_pkg::*;
    logic [31:0] gap_r;
    logic [31:0] gap_nxt;
    // Cycles since the last conversion start
    always_comb begin
        gap_nxt = gap_r + ((gap_r == 32'hffffffff) ? 32'h0 : 32'h1);
        if (o_conv_start) begin
            gap_nxt = 32'h1;
        end
    end
    always_ff @(posedge i_clock) begin
        if (!i_resetn) begin
            gap_r <= 32'hffffffff;
        end else begin
            gap_r <= gap_nxt;
        end
    end
    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (!i_resetn);
    sequence s_differential_input_mode_hi;
        i_chcfg_we && i_chcfg_differential_input_mode && (i_chcfg_chan >= DIFFERENTIAL_INPUT_MODE_LIMIT_CHAN);
    endsequence
    sequence s_ao_answer;
        o_ao_start && (o_ao_chan == $past(i_ao_chan));
    endsequence
    property p_pace;
        o_conv_start |-> gap_r >= 32'(o_ivl_us) * CYC_PER_US;
    endproperty
    a_pace: assert property (p_pace)
        else $error("conversion started too early");
    property p_ivl_rst;
        $rose(i_resetn) |-> o_ivl_us == 16'h0008;
    endproperty
    a_ivl_rst: assert property (p_ivl_rst)
        else $error("interval not 8 after reset");
    property p_ivl_load;
        i_ivl_we |=> o_ivl_us == $past(i_ivl_us);
    endproperty
    a_ivl_load: assert property (p_ivl_load)
        else $error("interval not loaded");
    property p_differential_input_mode_set;
        i_chcfg_we && (i_chcfg_chan < DIFFERENTIAL_INPUT_MODE_LIMIT_CHAN) |=>
            o_ai_differential_input_mode_mode[$past(i_chcfg_chan)] == $past(i_chcfg_differential_input_mode);
    endproperty
    a_differential_input_mode_set: assert property (p_differential_input_mode_set)
        else $error("terminal mode not taken");
    property p_differential_input_mode_refuse;
        s_differential_input_mode_hi |=> o_chcfg_err && $stable(o_ai_differential_input_mode_mode);
    endproperty
    a_differential_input_mode_refuse: assert property (p_differential_input_mode_refuse)
        else $error("differential accepted on high channel");
    property p_dio_dir;
        i_dio_dir_we |=> o_dio_oe_n == ~$past(i_dio_dir_out);
    endproperty
    a_dio_dir: assert property (p_dio_dir)
        else $error("line direction not taken");
    property p_done_pulse;
        o_rd_done |=> !o_rd_done;
    endproperty
    a_done_pulse: assert property (p_done_pulse)
        else $error("done longer than one cycle");
    property p_start_pulse;
        o_conv_start |=> !o_conv_start;
    endproperty
    a_start_pulse: assert property (p_start_pulse)
        else $error("start longer than one cycle");
    property p_ao;
        i_ao_wr |=> s_ao_answer;
    endproperty
    a_ao: assert property (p_ao)
        else $error("output write not answered");
endmodule : aiocp_chk
bind aiocp_top aiocp_chk u_aiocp_chk (.*);

// ==== tb/aiocp_conv_model.sv ====
`timescale 1ns/1ps
module aiocp_conv_model #(
    parameter int unsigned LAT = 3
) (
    input  wire logic        i_clock,
    input  wire logic        i_start,
    input  wire logic [3:0]  i_chan,
    input  wire logic [15:0] i_base,
    output logic             o_done,
    output logic [15:0]      o_code
);
    int unsigned cnt  = 0;
    logic [15:0] held = 16'h0000;
    initial begin
        o_done = 1'b0;
        o_code = 16'hffff;
    end
    // One answer per start, code idle shows inverse
    always @(posedge i_clock) begin
        o_done <= 1'b0;
        o_code <= ~held;
        if (i_start === 1'b1) begin
            cnt <= LAT;
        end else if (cnt == 1) begin
            cnt <= 0;
            o_done <= 1'b1;
            o_code <= i_base + {12'h000, i_chan};
            held <= i_base + {12'h000, i_chan};
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule : aiocp_conv_model

// ==== tb/aiocp_top_tb.sv ====
`timescale 1ns/1ps
module aiocp_top_tb;
    import aiocp_pkg::*;
    `define CHK(a, e) begin \
        checked++; \
        if ((a) !== (e)) begin \
            n_errors++; \
            $display("BAD %0t got %0h exp %0h", $time, (a), (e)); \
        end \
    end
    logic             i_clock = 1'b0, i_resetn = 1'b0, i_ai_cal_raw = 1'b0;
    logic             i_ao_cal_raw = 1'b0, i_cal_stored = 1'b0;
    aiocp_cal_t       i_ai_cal [4];
    aiocp_cal_t       i_ao_cal = 64'h0;
    logic             i_ivl_we = 1'b0, i_chcfg_we = 1'b0, i_chcfg_differential_input_mode = 1'b0;
    logic [IVL_W-1:0] i_ivl_us = 16'h0;
    logic [3:0]       i_chcfg_chan = 4'h0;
    aiocp_range_t     i_chcfg_range = AIOCP_RANGE_10V;
    logic [N_DIO-1:0] i_dio_default_out = 4'h5, i_dio_dir_out = 4'h0;
    logic             i_dio_dir_we = 1'b0, i_rd_req = 1'b0, i_ai_ready = 1'b1;
    logic [N_AI-1:0]  i_rd_mask = 16'h0, o_ai_differential_input_mode_mode;
    logic             i_ao_wr = 1'b0, i_conv_done, o_chcfg_err, o_rd_done;
    logic [1:0]       i_ao_chan = 2'h0, o_ao_chan;
    logic [AO_W-1:0]  i_ao_data = 20'h0;
    logic [15:0]      i_conv_code, o_ivl_us, o_ao_code, base = 16'h1000;
    logic [N_DIO-1:0] o_dio_oe_n;
    logic             o_ai_valid, o_conv_start, o_conv_differential_input_mode, o_ao_start;
    aiocp_word_t      o_ai_word;
    logic [3:0]       o_conv_chan;
    aiocp_range_t     o_conv_range;
    logic [1:0]       rng [16] = '{default: 2'h0};
    logic             dm [16] = '{default: 1'b0};
    aiocp_word_t      q [$];
    longint           st [$];
    longint           last_st = -1;
    int               checked = 0, n_errors = 0, ivl = 8;
    always #25 i_clock = ~i_clock;
    aiocp_top u_aiocp_top (.*);
    aiocp_conv_model #(.LAT(3)) u_aiocp_conv_model (
        .i_clock (i_clock),
        .i_start (o_conv_start),
        .i_chan  (o_conv_chan),
        .i_base  (base),
        .o_done  (i_conv_done),
        .o_code  (i_conv_code)
    );
    always @(posedge i_clock) begin
        if (o_ai_valid === 1'b1 && i_ai_ready === 1'b1) begin
            q.push_back(o_ai_word);
        end
        if (o_conv_start === 1'b1) begin
            st.push_back($time);
            `CHK(o_conv_range, rng[o_conv_chan])
            `CHK(o_conv_differential_input_mode, dm[o_conv_chan])
        end
    end
    function automatic logic [23:0] exp_ai(input logic [3:0] c);
        longint code;
        longint g;
        longint off;
        code = $signed(base + {12'h000, c});
        g = i_cal_stored ? i_ai_cal[rng[c]].gain_pv
                         : TYP_GAIN_PV[rng[c]];
        off = i_cal_stored ? i_ai_cal[rng[c]].offset_nv : 0;
        if (i_ai_cal_raw) begin
            return {{8{code[15]}}, code[15:0]};
        end
        return 24'(((code * g - off * NV_TO_PV) * CAL_MULT) >>> CAL_SHIFT);
    endfunction : exp_ai
    task automatic conclude;
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude
    task automatic cfg(input logic [3:0] ch, input logic [1:0] r,
                       input logic d);
        @(negedge i_clock);
        i_chcfg_we = 1'b1;
        i_chcfg_chan = ch;
        i_chcfg_range = aiocp_range_t'(r);
        i_chcfg_differential_input_mode = d;
        @(negedge i_clock);
        i_chcfg_we = 1'b0;
        rng[ch] = r;
        dm[ch] = ch[3] ? dm[ch] : d;
        `CHK(o_chcfg_err, d & ch[3])
        `CHK(o_ai_differential_input_mode_mode[ch], dm[ch])
    endtask : cfg
    task automatic set_ivl(input int us);
        @(negedge i_clock);
        i_ivl_we = 1'b1;
        i_ivl_us = 16'(us);
        @(negedge i_clock);
        i_ivl_we = 1'b0;
        ivl = us;
        `CHK(o_ivl_us, 16'(us))
    endtask : set_ivl
    task automatic rd(input logic [15:0] mask, input int stall);
        int n;
        int k;
        longint ns;
        q.delete();
        st.delete();
        ns = longint'(ivl) * CYC_PER_US * 50;
        @(negedge i_clock);
        i_rd_mask = mask;
        i_rd_req = 1'b1;
        i_ai_ready = (stall == 0);
        for (n = 0; n < 20000 && o_rd_done !== 1'b1; n++) begin
            @(negedge i_clock);
            i_ai_ready = (n >= stall);
        end
        i_rd_req = 1'b0;
        i_ai_ready = 1'b1;
        for (k = 0; k < 50 && q.size() < $countones(mask); k++) begin
            @(negedge i_clock);
        end
        if (n >= 20000 || k >= 50 || st.size() == 0) begin
            n_errors++;
            conclude();
        end
        `CHK(q.size(), $countones(mask))
        if (last_st >= 0 && stall == 0) begin
            `CHK(st[0] - last_st >= ns, 1'b1)
        end
        for (n = 1; n < st.size() && stall == 0; n++) begin
            `CHK(st[n] - st[n-1], ns)
        end
        last_st = st[st.size()-1];
        k = 0;
        for (n = 0; n < 16; n++) begin
            if (mask[n]) begin
                `CHK(q[k].chan, n[3:0])
                `CHK(q[k].data, exp_ai(n[3:0]))
                `CHK(q[k].last, k == $countones(mask) - 1)
                k++;
            end
        end
        $display("test read %h done", mask);
    endtask : rd
    task automatic ao(input logic [1:0] ch, input logic [19:0] v,
                      input logic [15:0] e);
        @(negedge i_clock);
        i_ao_wr = 1'b1;
        i_ao_chan = ch;
        i_ao_data = v;
        @(negedge i_clock);
        i_ao_wr = 1'b0;
        `CHK({o_ao_start, o_ao_chan, o_ao_code}, {1'b1, ch, e})
    endtask : ao
    initial begin
        for (int r = 0; r < 4; r++) begin
            i_ai_cal[r] = {TYP_GAIN_PV[r] + 32'sd1000, 32'sd250000 * r};
        end
        repeat (2) @(negedge i_clock);
        i_resetn = 1'b1;
        @(negedge i_clock);
        `CHK(o_ivl_us, 16'h0008)
        `CHK(o_dio_oe_n, 4'ha)
        `CHK(o_ai_differential_input_mode_mode, 16'h0000)
        $display("test reset done");
        for (int c = 0; c < 4; c++) begin
            cfg(4'(c), 2'(c), c[0]);
        end
        cfg(4'h9, 2'h1, 1'b1);
        cfg(4'h8, 2'h2, 1'b0);
        $display("test config done");
        rd(16'h000f, 0);
        i_cal_stored = 1'b1;
        rd(16'h0003, 0);
        set_ivl(1);
        i_ai_cal_raw = 1'b1;
        base = 16'hf800;
        rd(16'h0104, 0);
        set_ivl(0);
        rd(16'hffff, 400);
        @(negedge i_clock);
        i_dio_dir_we = 1'b1;
        i_dio_dir_out = 4'h3;
        @(negedge i_clock);
        i_dio_dir_we = 1'b0;
        `CHK(o_dio_oe_n, 4'hc)
        $display("test direction done");
        i_cal_stored = 1'b0;
        ao(2'h1, 20'h08000, 16'h0c35);
        ao(2'h2, 20'hf0000, 16'he796);
        i_cal_stored = 1'b1;
        i_ao_cal.offset_nv = 32'sd1000000000;
        ao(2'h1, 20'h10000, 16'h0c35);
        i_ao_cal_raw = 1'b1;
        ao(2'h3, 20'h00c35, 16'h0c35);
        ao(2'h0, 20'h08001, 16'h8001);
        $display("test output done");
        conclude();
    end
endmodule : aiocp_top_tb
